// File: hdl/rx_sig_map.vh
`ifndef RX_SIG_MAP_VH
`define RX_SIG_MAP_VH
// Counter register offsets
`define LINE_VIOL_HIGH_OFS 8'h50
`define LINE_VIOL_LOW_OFS 8'h51
`define PATH_VIOL_HIGH_OFS 8'h52
`define PATH_VIOL_LOW_OFS 8'h53
`define SYNC_LOSS_HIGH_OFS 8'h54
`define SYNC_LOSS_LOW_OFS 8'h55
// Signaling storage window: one byte per channel, ABCD in bits 3:0
`define SIG_BASE_OFS 8'h40
`define SIG_LAST_OFS 8'h4f
// Control register: bit 0 selects extended superframe mode
`define CTRL_OFS 8'h5f
`define CTRL_ESF_BIT 0
// Status register: bit 0 live frame alignment lost
`define STAT_OFS 8'h5e
`define STAT_OOF_BIT 0
// Reset values
`define COUNT_RST 16'h0000
`define SIG_RST 4'h0
`define CTRL_RST 8'h00
// Recommended host poll intervals, in microseconds
`define POLL_D4_US 1500
`define POLL_ESF_US 3000
`define CLK_MHZ 250
`define POLL_D4_CYC (`POLL_D4_US * `CLK_MHZ)
`define POLL_ESF_CYC (`POLL_ESF_US * `CLK_MHZ)
`endif

// File: hdl/event_tally.v
`timescale 1ns/1ns
`include "rx_sig_map.vh"
module event_tally #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Event
  input wire event_i,
  // Count
  output wire [WIDTH-1:0] count_o
);
  reg [WIDTH-1:0] count_ff;
  wire [WIDTH-1:0] nxt_count;

  // Wraps at full scale; software polls before overflow
  assign nxt_count = event_i ? count_ff + {{(WIDTH-1){1'b0}}, 1'b1} : count_ff;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      count_ff <= {WIDTH{1'b0}}; // R12
    end else begin
      count_ff <= nxt_count; // R12
    end
  end

  assign count_o = count_ff;
endmodule // event_tally

// File: hdl/rx_signaling_error_counters.v
`timescale 1ns/1ns
`include "rx_sig_map.vh"
// How it works
// R1 - In extended superframe mode all four bits A, B, C and D of a channel are stored.
// R2 - In D4 mode only the A and B bits of a channel are taken from the line.
// R3 - In D4 mode the A and B values are copied into the C and D positions.
// R4 - Software should read the signaling every 1.5 ms in D4 or 3 ms in extended superframe mode.
// R5 - While frame alignment is lost the signaling store holds its last values.
// R6 - The line violation tally is 16 bits and its upper byte reads at 50h.
// R7 - The line violation tally's lower byte reads at 51h.
// R8 - The path violation tally is 16 bits and its upper byte reads at 52h.
// R9 - The path violation tally's lower byte reads at 53h.
// R10 - The sync loss tally is 16 bits and its upper byte reads at 54h.
// R11 - The sync loss tally's lower byte reads at 55h.
// R12 - Each tally resets to zero and counts one per event of its kind.
module rx_signaling_error_counters #(
  parameter CHANNELS = 16,
  parameter CH_BITS = 4
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Receive framer side
  input wire sig_valid_i,
  input wire [CH_BITS-1:0] sig_channel_i,
  input wire [3:0] sig_abcd_i,
  input wire frame_alignment_lost_i,
  input wire line_violation_i,
  input wire path_violation_i,
  input wire sync_loss_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [7:0] rdata_o,
  // Mode view
  output wire esf_mode_o
);
  reg [7:0] ctrl_ff;
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg [3:0] sig_mem [0:CHANNELS-1];
  reg oof_s1_ff;
  reg oof_s2_ff;
  reg oof_s3_ff;
  reg oof_ff;
  wire [15:0] line_violation_tally;
  wire [15:0] path_violation_tally;
  wire [15:0] sync_loss_tally;
  wire esf_mode;
  reg [3:0] sig_store_val;
  reg [7:0] nxt_ctrl;
  reg [7:0] cnt_rdata;
  reg [7:0] sig_rdata;
  reg [7:0] cfg_rdata;
  reg cnt_hit;
  reg sig_hit;
  reg cfg_hit;
  reg nxt_oof;
  wire ctrl_wr;
  wire sig_take;
  wire [CHANNELS-1:0] sig_we;
  wire [CH_BITS-1:0] rd_channel;
  integer i;
  genvar g;

  function [7:0] byte_of;
    input [15:0] value;
    input high;
    begin
      byte_of = high ? value[15:8] : value[7:0];
    end
  endfunction

  // Address decodes; is_reg is shared by the write and read paths, the signaling decodes serve reads only
  function is_reg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_reg = (addr == ofs);
    end
  endfunction

  function is_sig_addr;
    input [7:0] addr;
    reg [7:0] ofs;
    begin
      ofs = addr - `SIG_BASE_OFS;
      is_sig_addr = (addr >= `SIG_BASE_OFS) && (addr <= `SIG_LAST_OFS) && (ofs < CHANNELS);
    end
  endfunction

  function [CH_BITS-1:0] chan_of;
    input [7:0] addr;
    reg [7:0] ofs;
    begin
      ofs = addr - `SIG_BASE_OFS;
      chan_of = ofs[CH_BITS-1:0];
    end
  endfunction

  function [3:0] d4_repeat;
    input [3:0] abcd;
    begin
      d4_repeat = {abcd[3:2], abcd[3:2]};
    end
  endfunction

  assign esf_mode = ctrl_ff[`CTRL_ESF_BIT];
  assign esf_mode_o = esf_mode;

  // Alignment flag may come from another domain; accept when stages 2 and 3 agree
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      oof_s1_ff <= 1'b0;
      oof_s2_ff <= 1'b0;
      oof_s3_ff <= 1'b0;
      oof_ff <= 1'b0;
    end else begin
      oof_s1_ff <= frame_alignment_lost_i;
      oof_s2_ff <= oof_s1_ff;
      oof_s3_ff <= oof_s2_ff;
      oof_ff <= nxt_oof;
    end
  end

  always @* begin
    nxt_oof = oof_ff;
    if (oof_s2_ff == oof_s3_ff) begin
      nxt_oof = oof_s3_ff;
    end
  end

  // D4 carries only A and B; repeat them into C and D
  always @* begin
    case (esf_mode)
      1'b1: sig_store_val = sig_abcd_i; // R1
      default: sig_store_val = d4_repeat(sig_abcd_i); // R2 R3
    endcase
  end

  // A lost frame keeps the last bits captured while aligned
  assign sig_take = sig_valid_i && !oof_ff; // R5

  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_sig_we
      assign sig_we[g] = sig_take && ({{(32-CH_BITS){1'b0}}, sig_channel_i} == g);
    end
  endgenerate

  always @(posedge mclk_i) begin
    for (i = 0; i < CHANNELS; i = i + 1) begin
      if (!rst_n_i) begin
        sig_mem[i] <= `SIG_RST;
      end else if (sig_we[i]) begin
        sig_mem[i] <= sig_store_val; // R1 R3
      end
    end
  end

  assign ctrl_wr = wr_i && is_reg(addr_i, `CTRL_OFS);

  // Only the mode bit is kept; the rest read back as zero
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl = `CTRL_RST;
      nxt_ctrl[`CTRL_ESF_BIT] = wdata_i[`CTRL_ESF_BIT];
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  event_tally #(.WIDTH(16)) u_line (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(line_violation_i),
    .count_o(line_violation_tally)
  ); // R6 R12
  event_tally #(.WIDTH(16)) u_path (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(path_violation_i),
    .count_o(path_violation_tally)
  ); // R8 R12
  event_tally #(.WIDTH(16)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(sync_loss_i),
    .count_o(sync_loss_tally)
  ); // R10 R12

  // Counter bytes; no latch between the two reads, so a busy tally may tear
  always @* begin
    cnt_hit = 1'b1;
    cnt_rdata = 8'h00;
    case (addr_i)
      `LINE_VIOL_HIGH_OFS: begin
        cnt_rdata = byte_of(line_violation_tally, 1'b1); // R6
      end
      `LINE_VIOL_LOW_OFS: begin
        cnt_rdata = byte_of(line_violation_tally, 1'b0); // R7
      end
      `PATH_VIOL_HIGH_OFS: begin
        cnt_rdata = byte_of(path_violation_tally, 1'b1); // R8
      end
      `PATH_VIOL_LOW_OFS: begin
        cnt_rdata = byte_of(path_violation_tally, 1'b0); // R9
      end
      `SYNC_LOSS_HIGH_OFS: begin
        cnt_rdata = byte_of(sync_loss_tally, 1'b1); // R10
      end
      `SYNC_LOSS_LOW_OFS: begin
        cnt_rdata = byte_of(sync_loss_tally, 1'b0); // R11
      end
      default: begin
        cnt_hit = 1'b0;
      end
    endcase
  end

  assign rd_channel = chan_of(addr_i);

  always @* begin
    sig_hit = is_sig_addr(addr_i);
    sig_rdata = 8'h00;
    if (sig_hit) begin
      sig_rdata[3:0] = sig_mem[rd_channel]; // R1 R3
    end
  end

  always @* begin
    cfg_hit = 1'b0;
    cfg_rdata = 8'h00;
    if (is_reg(addr_i, `CTRL_OFS)) begin
      cfg_hit = 1'b1;
      cfg_rdata = ctrl_ff;
    end else if (is_reg(addr_i, `STAT_OFS)) begin
      cfg_hit = 1'b1;
      cfg_rdata[`STAT_OOF_BIT] = oof_ff; // R5
    end
  end

  // The three windows never overlap, so the order is free
  always @* begin
    if (cnt_hit) begin
      nxt_rdata = cnt_rdata;
    end else if (sig_hit) begin
      nxt_rdata = sig_rdata;
    end else if (cfg_hit) begin
      nxt_rdata = cfg_rdata;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  // Read data stands one cycle after the strobe only
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd_i ? nxt_rdata : 8'h00;
    end
  end

  assign rdata_o = rdata_ff;
endmodule // rx_signaling_error_counters

// File: tb/framer_model.sv
`timescale 1ns/1ns
module framer_model (
  input wire mclk_i,
  output logic sig_valid_o = 1'b0,
  output logic [3:0] sig_channel_o = 4'h0,
  output logic [3:0] sig_abcd_o = 4'h0,
  output logic [2:0] event_o = 3'h0
);
  task sig(input [3:0] ch, input [3:0] abcd);
    @(posedge mclk_i);
    sig_valid_o <= 1'b1;
    sig_channel_o <= ch;
    sig_abcd_o <= abcd;
    @(posedge mclk_i);
    sig_valid_o <= 1'b0;
    // Stale word inverted so a late capture shows
    sig_abcd_o <= ~abcd;
  endtask
  task events(input [2:0] kinds, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      event_o <= kinds;
    end
    @(posedge mclk_i);
    event_o <= 3'h0;
  endtask
endmodule // framer_model

// File: tb/rx_counters_monitor.sv
`timescale 1ns/1ns
module rx_counters_monitor (
  // Watched ports
  input wire mclk_i, rst_n_i, line_violation_i, path_violation_i, sync_loss_i, rd_i, esf_mode_o,
  input wire [7:0] addr_i, rdata_o
);
  logic [15:0] c0, c1, c2;
  always_ff @(posedge mclk_i) begin
    c0 <= rst_n_i ? c0 + line_violation_i : 16'h0000;
    c1 <= rst_n_i ? c1 + path_violation_i : 16'h0000;
    c2 <= rst_n_i ? c2 + sync_loss_i : 16'h0000;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_cnt(a, v);
    rd_i && addr_i == a |=> rdata_o == v;
  endproperty
  a_line_high: assert property (p_cnt(8'h50, $past(c0[15:8]))) else $error("50h");
  a_line_low: assert property (p_cnt(8'h51, $past(c0[7:0]))) else $error("51h");
  a_path_high: assert property (p_cnt(8'h52, $past(c1[15:8]))) else $error("52h");
  a_path_low: assert property (p_cnt(8'h53, $past(c1[7:0]))) else $error("53h");
  a_sync_high: assert property (p_cnt(8'h54, $past(c2[15:8]))) else $error("54h");
  a_sync_low: assert property (p_cnt(8'h55, $past(c2[7:0]))) else $error("55h");
  a_d4_copy: assert property (rd_i && addr_i[7:4] == 4'h4 && !esf_mode_o |=> rdata_o[3:2] == rdata_o[1:0]) else $error("d4");
  a_sig_nibble: assert property (rd_i && addr_i[7:4] == 4'h4 |=> rdata_o[7:4] == 4'h0) else $error("sig");
  cover property (rd_i && addr_i == 8'h55);
  cover property (rd_i && addr_i == 8'h45 && !esf_mode_o);
  cover property (line_violation_i && sync_loss_i);
endmodule // rx_counters_monitor

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, frame_alignment_lost_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  wire [7:0] rdata_o;
  wire [3:0] sig_channel_i, sig_abcd_i;
  wire esf_mode_o, sig_valid_i, line_violation_i, path_violation_i, sync_loss_i;
  int miscompares = 0, comparisons = 0, cycles = 0;
  logic [7:0] tally_exp [6] = '{8'h01, 8'h05, 8'h01, 8'h03, 8'h01, 8'h00};
  initial forever #2 mclk_i = ~mclk_i;
  rx_signaling_error_counters i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sig_valid_i(sig_valid_i),
    .sig_channel_i(sig_channel_i), .sig_abcd_i(sig_abcd_i), .frame_alignment_lost_i(frame_alignment_lost_i),
    .line_violation_i(line_violation_i), .path_violation_i(path_violation_i), .sync_loss_i(sync_loss_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .esf_mode_o(esf_mode_o));
  framer_model i_framer (.mclk_i(mclk_i), .sig_valid_o(sig_valid_i), .sig_channel_o(sig_channel_i),
    .sig_abcd_o(sig_abcd_i), .event_o({sync_loss_i, path_violation_i, line_violation_i}));
  task report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Reads compare against d; host polls signaling within 1.5 ms (D4) or 3 ms
  task acc(input bit w, input [7:0] a, input [7:0] d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1;
    if (!w) begin
      comparisons++;
      if (rdata_o !== d) begin
        miscompares++;
        $display("mismatch reg %h expected %h seen %h", a, d, rdata_o);
      end
    end
  endtask
  task chk_mode(input logic exp);
    comparisons++;
    if (esf_mode_o !== exp) begin
      miscompares++;
      $display("mismatch esf_mode_o expected %b seen %b", exp, esf_mode_o);
    end
  endtask
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    acc(1, 8'h51, 8'hff);
    for (int k = 0; k < 6; k++) acc(0, 8'h50 + k[7:0], 8'h00);
    i_framer.events(3'b111, 256);
    i_framer.events(3'b011, 3);
    i_framer.events(3'b001, 2);
    for (int k = 0; k < 6; k++) acc(0, 8'h50 + k[7:0], tally_exp[k]);
    $display("counters done");
    acc(1, 8'h5f, 8'h01);
    acc(0, 8'h5f, 8'h01);
    chk_mode(1'b1);
    i_framer.sig(4'h3, 4'hc);
    acc(0, 8'h43, 8'h0c);
    acc(1, 8'h5f, 8'h00);
    chk_mode(1'b0);
    i_framer.sig(4'h5, 4'h7);
    acc(0, 8'h45, 8'h05);
    @(posedge mclk_i);
    frame_alignment_lost_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    acc(0, 8'h5e, 8'h01);
    i_framer.sig(4'h5, 4'he);
    acc(0, 8'h45, 8'h05);
    @(posedge mclk_i);
    frame_alignment_lost_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    acc(0, 8'h5e, 8'h00);
    i_framer.sig(4'h5, 4'h8);
    acc(0, 8'h45, 8'h0a);
    $display("signaling done");
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 6; k++) acc(0, 8'h50 + k[7:0], 8'h00);
    acc(0, 8'h45, 8'h00);
    chk_mode(1'b0);
    $display("reset done");
    report_and_stop();
  end
endmodule // tb
bind rx_signaling_error_counters rx_counters_monitor i_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .line_violation_i(line_violation_i), .path_violation_i(path_violation_i), .sync_loss_i(sync_loss_i),
  .rd_i(rd_i), .esf_mode_o(esf_mode_o), .addr_i(addr_i), .rdata_o(rdata_o));
